// File: logic/iep_top.sv
// Purpose: Interrupt enable and priority registers with request gating.
// Assumes: Request flags and CPU strobes come from logic on aclk.
// Notes:   Registers sit on an AXI4-Lite slave; unmapped accesses get SLVERR.
//
// Design decision made here: the AXI4-Lite slave port.
module iep_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [iep_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [iep_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [iep_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [iep_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [iep_pkg::NSRC-1:0]     irq_req,
  input  wire logic                         svc_enter,
  input  wire logic                         svc_exit,
  output logic                              irq_valid,
  output logic [iep_pkg::SRC_W-1:0]         irq_src,
  output logic [iep_pkg::LVL_W-1:0]         irq_lvl
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]                      enable_q,  enable_d;
  logic [7:0]                      prio_lo_q, prio_lo_d;
  logic [7:0]                      prio_hi_q, prio_hi_d;
  logic [iep_pkg::NLVL-1:0]        isr_q,     isr_d;
  logic                            irq_valid_q, irq_valid_d;
  logic [iep_pkg::SRC_W-1:0]       irq_src_q,   irq_src_d;
  logic [iep_pkg::LVL_W-1:0]       irq_lvl_q,   irq_lvl_d;
  logic                            aw_hold_q, aw_hold_d;
  logic [iep_pkg::ADDR_W-1:0]      aw_addr_q, aw_addr_d;
  logic                            w_hold_q,  w_hold_d;
  logic [7:0]                      w_data_q,  w_data_d;
  logic                            w_strb_q,  w_strb_d;
  logic                            awready_q, awready_d;
  logic                            wready_q,  wready_d;
  logic                            bvalid_q,  bvalid_d;
  logic [1:0]                      bresp_q,   bresp_d;
  logic                            arready_q, arready_d;
  logic                            rvalid_q,  rvalid_d;
  logic [1:0]                      rresp_q,   rresp_d;
  logic [iep_pkg::DATA_W-1:0]      rdata_q,   rdata_d;
  logic                            do_write;
  logic                            isr_any;
  logic [iep_pkg::LVL_W-1:0]       isr_top;

  iep_arb_if bif ();

  ////////////////////////////////////////////////////////////////////////////
  // Per-source level and eligibility
  generate
    for (genvar g = 0; g < iep_pkg::NSRC; g++) begin : g_src
      assign bif.lvl[g]  = {prio_hi_q[g], prio_lo_q[g]};
      assign bif.elig[g] = enable_q[iep_pkg::GLOB_BIT]
                         & enable_q[g]
                         & irq_req[g]
                         & ~(prio_lo_q[iep_pkg::LVL0_MASK_BIT]
                             & (bif.lvl[g] == 2'h0))
                         & ~(prio_hi_q[iep_pkg::LVL1_MASK_BIT]
                             & (bif.lvl[g] == 2'h1));
    end
  endgenerate

  // Highest level now in service
  always_comb begin
    isr_any = 1'b0;
    isr_top = '0;
    for (int i = 0; i < iep_pkg::NLVL; i++) begin
      if (isr_q[i]) begin
        isr_any = 1'b1;
        isr_top = iep_pkg::LVL_W'(i);
      end
    end
  end

  assign bif.busy    = isr_any;
  assign bif.cur_lvl = isr_top;

  iep_arbiter u_arb (
    .bif (bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request output and in-service tracking
  always_comb begin
    irq_valid_d = bif.win_valid;
    irq_src_d   = bif.win_src;
    irq_lvl_d   = bif.win_lvl;
    isr_d       = isr_q;
    if (svc_exit && isr_any) begin
      isr_d[isr_top] = 1'b0;       // Return closes newest level
    end
    if (svc_enter && irq_valid_q) begin
      isr_d[irq_lvl_q] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_valid_q <= 1'b0;
      irq_src_q   <= '0;
      irq_lvl_q   <= '0;
      isr_q       <= '0;
    end else begin
      irq_valid_q <= irq_valid_d;
      irq_src_q   <= irq_src_d;
      irq_lvl_q   <= irq_lvl_d;
      isr_q       <= isr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    enable_d  = enable_q;
    prio_lo_d = prio_lo_q;
    prio_hi_d = prio_hi_q;
    if (s_axi_awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_strb_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = iep_pkg::RESP_OKAY;
      unique case (aw_addr_q)
        iep_pkg::OFS_ENABLE:  if (w_strb_q) enable_d  = w_data_q;
        iep_pkg::OFS_PRIO_LO: if (w_strb_q) prio_lo_d = w_data_q;
        iep_pkg::OFS_PRIO_HI: if (w_strb_q) prio_hi_d = w_data_q;
        iep_pkg::OFS_STATUS:  ;
        default:              bresp_d = iep_pkg::RESP_SLVERR;
      endcase
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d  = !w_hold_d && !bvalid_d;
  end

  // Write registers; enables and priorities clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= iep_pkg::RESP_OKAY;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      enable_q  <= iep_pkg::RST_ENABLE;
      prio_lo_q <= iep_pkg::RST_PRIO_LO;
      prio_hi_q <= iep_pkg::RST_PRIO_HI;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      enable_q  <= enable_d;
      prio_lo_q <= prio_lo_d;
      prio_hi_q <= prio_hi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = iep_pkg::RESP_OKAY;
      rdata_d  = '0;
      unique case (s_axi_araddr)
        iep_pkg::OFS_ENABLE:  rdata_d[7:0] = enable_q;
        iep_pkg::OFS_PRIO_LO: rdata_d[7:0] = prio_lo_q;
        iep_pkg::OFS_PRIO_HI: rdata_d[7:0] = prio_hi_q;
        iep_pkg::OFS_STATUS: begin
          rdata_d[iep_pkg::STAT_ISR_LSB +: iep_pkg::NLVL]  = isr_q;
          rdata_d[iep_pkg::STAT_VALID_BIT]                 = irq_valid_q;
          rdata_d[iep_pkg::STAT_SRC_LSB +: iep_pkg::SRC_W] = irq_src_q;
          rdata_d[iep_pkg::STAT_LVL_LSB +: iep_pkg::LVL_W] = irq_lvl_q;
        end
        default: rresp_d = iep_pkg::RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q  <= 1'b0;
      rresp_q   <= iep_pkg::RESP_OKAY;
      rdata_q   <= '0;
      arready_q <= 1'b0;
    end else begin
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      arready_q <= arready_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq_valid     = irq_valid_q;
  assign irq_src       = irq_src_q;
  assign irq_lvl       = irq_lvl_q;

endmodule

// File: pkg/iep_pkg.sv
// Purpose: Constants for the interrupt enable and low priority block.
// Assumes: 32-bit AXI4-Lite data, 8-bit byte addresses, seven sources.
// Notes:   Source index order equals ascending vector order.
// Behaviour
// - With the global enable bit 7 low, no source is admitted at all.
// - With the global enable high, a source is admitted only if its own enable bit is one.
// - The enable register lives at 0xa8 and resets to all zeros.
// - Bit 7 of the low priority register blocks every source at level zero.
// - Bits 6 to 0 of the low priority register hold each source's low priority bit.
// - Each source has one of four levels built from its low and high priority bits.
// - Only a strictly higher level pre-empts; equal levels go to the lower vector.
// - Bit 7 of the high priority register blocks every source at level one.
package iep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NSRC   = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 2;
  localparam int NLVL   = 4;
  localparam int SRC_W  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'ha8;
  localparam logic [ADDR_W-1:0] OFS_PRIO_LO = 8'hb8;
  localparam logic [ADDR_W-1:0] OFS_PRIO_HI = 8'hbc;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'hc0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions
  localparam logic [7:0] RST_ENABLE  = 8'h00;
  localparam logic [7:0] RST_PRIO_LO = 8'h00;
  localparam logic [7:0] RST_PRIO_HI = 8'h00;
  localparam int GLOB_BIT       = 7;
  localparam int LVL0_MASK_BIT  = 7;
  localparam int LVL1_MASK_BIT  = 7;
  localparam int STAT_ISR_LSB   = 0;
  localparam int STAT_VALID_BIT = 4;
  localparam int STAT_SRC_LSB   = 5;
  localparam int STAT_LVL_LSB   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: pkg/iep_arb_if.sv
// Purpose: Carries eligibility and levels to the arbiter and its result back.
// Assumes: Purely combinational between the two modules.
// Notes:   The winner is only meaningful while win_valid is high.
interface iep_arb_if;
  logic [iep_pkg::NSRC-1:0]                     elig;
  logic [iep_pkg::NSRC-1:0][iep_pkg::LVL_W-1:0] lvl;
  logic                                         busy;
  logic [iep_pkg::LVL_W-1:0]                    cur_lvl;
  logic                                         win_valid;
  logic [iep_pkg::SRC_W-1:0]                    win_src;
  logic [iep_pkg::LVL_W-1:0]                    win_lvl;

  modport ctl (output elig, lvl, busy, cur_lvl, input win_valid, win_src, win_lvl);
  modport arb (input elig, lvl, busy, cur_lvl, output win_valid, win_src, win_lvl);
endinterface

// File: logic/iep_arbiter.sv
// Purpose: Picks the winning request and checks it against the service level.
// Assumes: Eligibility already includes enables and level masks.
// Notes:   Combinational only; the caller registers the result.
module iep_arbiter (
  iep_arb_if.arb bif
);

  logic                           best_v;
  logic [iep_pkg::LVL_W-1:0]      best_l;
  logic [iep_pkg::SRC_W-1:0]      best_s;

  // Highest level wins, lowest index breaks ties
  always_comb begin
    best_v = 1'b0;
    best_l = '0;
    best_s = '0;
    for (int i = 0; i < iep_pkg::NSRC; i++) begin
      if (bif.elig[i] && (!best_v || bif.lvl[i] > best_l)) begin
        best_v = 1'b1;
        best_l = bif.lvl[i];
        best_s = iep_pkg::SRC_W'(i);
      end
    end
  end

  // Only a strictly higher level may pre-empt
  always_comb begin
    bif.win_valid = best_v && (!bif.busy || best_l > bif.cur_lvl);
    bif.win_src   = best_s;
    bif.win_lvl   = best_l;
  end

endmodule

// File: test/iep_top_chk.sv
// Purpose: Port-level properties of the enable and priority block.
// Assumes: Register writes offer address and data together.
// Notes:   Byte shadows trail the bus; checks look back up to three edges.
module iep_top_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [6:0]  irq_req,
  input wire logic        irq_valid,
  input wire logic [2:0]  irq_src,
  input wire logic [1:0]  irq_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_hit;
  logic [7:0] en_q;
  logic [7:0] lo_q;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows of the enable and low priority bytes
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (wr_hit && s_axi_wstrb[0] && s_axi_awaddr == iep_pkg::OFS_ENABLE) begin
      en_q <= s_axi_wdata[7:0];
    end else if (wr_hit && s_axi_wstrb[0] && s_axi_awaddr == iep_pkg::OFS_PRIO_LO) begin
      lo_q <= s_axi_wdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> !irq_valid && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_glob;
    irq_valid |-> $past(en_q[7], 1) || $past(en_q[7], 2) || $past(en_q[7], 3);
  endproperty
  a_glob: assert property (p_glob) else $error("request with global off");
  property p_own;
    irq_valid |->
      ((($past(en_q, 1) | $past(en_q, 2) | $past(en_q, 3)) >> irq_src) & 8'h01) != 8'h00;
  endproperty
  a_own: assert property (p_own) else $error("request with own enable off");
  property p_req;
    irq_valid |-> (($past(irq_req) >> irq_src) & 7'h01) == 7'h01;
  endproperty
  a_req: assert property (p_req) else $error("winner without a request");
  property p_lvl0;
    irq_valid && irq_lvl == 2'h0 |->
      !($past(lo_q[7], 1) && $past(lo_q[7], 2) && $past(lo_q[7], 3));
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("level zero not blocked");
  // Answer is registered one edge after both halves are held
  property p_bans;
    wr_hit |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("no write answer");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule

bind iep_top iep_top_chk chk (.*);

// File: test/iep_cpu_model.sv
// Purpose: CPU core and peripheral request flags beside the block.
// Assumes: The bench raises take or ret for a single cycle.
// Notes:   Vectors only to a request offered at that edge.
module iep_cpu_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [6:0] flags,
  input wire logic       take,
  input wire logic       ret,
  input wire logic       irq_valid,
  output logic [6:0]     irq_req,
  output logic           svc_enter,
  output logic           svc_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags follow a cycle late; service strobes last one cycle
  always_ff @(posedge aclk) begin
    irq_req   <= aresetn ? flags : 7'h00;
    svc_enter <= aresetn && take && irq_valid;
    svc_exit  <= aresetn && ret;
  end
endmodule

// File: test/irq_enable_and_low_priority_test.sv
// Purpose: Self-checking bench for the enable and priority block.
// Assumes: Status word at 0xc0, high priority byte at 0xbc.
// Notes:   Reads note expected words; a monitor compares them.
module irq_enable_and_low_priority_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [33:0] INV_M = 34'h3fffffc1f; // Ignore source and level
  logic        aclk, aresetn, take, ret, svc_enter, svc_exit, irq_valid;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, v;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, irq_lvl;
  logic [2:0]  irq_src;
  logic [6:0]  flags, irq_req;
  logic [33:0] rq[$], mq[$], m;
  logic [1:0]  bq[$];
  int          err_total, checks, i;

  iep_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req), .svc_enter(svc_enter), .svc_exit(svc_exit), .irq_valid(irq_valid),
    .irq_src(irq_src), .irq_lvl(irq_lvl));
  iep_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .flags(flags), .take(take), .ret(ret),
    .irq_valid(irq_valid), .irq_req(irq_req), .svc_enter(svc_enter), .svc_exit(svc_exit));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict, bus tasks
  task automatic cmp(input string nm, input logic [33:0] exp, input logic [33:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0,
                    input logic [3:0] s = 4'h1);
    int n, lag;
    @(posedge aclk);
    bq.push_back(r);
    lag = $urandom % 4;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (n >= lag) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 64) begin
      err_total++;
      wrap_up;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] k = '1);
    int n, lag;
    @(posedge aclk);
    rq.push_back(e & k);
    mq.push_back(k);
    lag = $urandom % 4;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (n >= lag) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 64) begin
      err_total++;
      wrap_up;
    end
  endtask
  function automatic logic [33:0] st(input logic vl, input logic [2:0] s, input logic [1:0] l,
                                     input logic [3:0] isr);
    return {24'h0, l, s, vl, isr};
  endfunction
  task automatic pulse(input logic t);
    if (t) take <= 1'b1;
    else ret <= 1'b1;
    @(posedge aclk);
    take <= 1'b0;
    ret <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // Monitor: each answer against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      m = (mq.size() > 0) ? mq.pop_front() : '1;
      cmp("read", (rq.size() > 0) ? rq.pop_front() : 34'hx, {rresp, rdata} & m);
    end
    if (bvalid && bready) cmp("bresp", {32'h0, (bq.size() > 0) ? bq.pop_front() : 2'hx},
                              {32'h0, bresp});
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, take, ret, aresetn} = '0;
    {awaddr, araddr, wdata, wstrb, flags, err_total, checks} = '0;
    void'($urandom(32'h6b71bb4d));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'ha8, 34'h0);
    rd(8'hb8, 34'h0);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'ha8, v);
      rd(8'ha8, {26'h0, v});
      wr(8'hb8, ~v);
      rd(8'hb8, {26'h0, ~v});
    end
    wr(8'h04, 8'hff, 2'h2);
    rd(8'h04, {2'h2, 32'h0});
    wr(8'hc0, 8'hff);
    wr(8'ha8, 8'h5a, 2'h0, 4'h0);
    rd(8'ha8, {26'h0, v});
    wr(8'hb8, 8'h00);
    // Each source: global off, own off, both on
    for (i = 0; i < 7; i++) begin
      flags <= 7'h01 << i;
      wr(8'ha8, 8'h7f);
      rd(8'hc0, st(0, 0, 0, 0), INV_M);
      wr(8'ha8, 8'h80 | ~(8'h01 << i));
      rd(8'hc0, st(0, 0, 0, 0), INV_M);
      wr(8'ha8, 8'h80 | (8'h01 << i));
      rd(8'hc0, st(1, i[2:0], 0, 0));
    end
    flags <= 7'h7f;
    wr(8'ha8, 8'hff);
    rd(8'hc0, st(1, 0, 0, 0));
    wr(8'hb8, 8'h80);
    rd(8'hc0, st(0, 0, 0, 0), INV_M);
    wr(8'hb8, 8'h88);
    rd(8'hc0, st(1, 3, 1, 0));
    wr(8'hbc, 8'h80);
    rd(8'hc0, st(0, 0, 0, 0), INV_M);
    wr(8'hbc, 8'ha0);
    rd(8'hc0, st(1, 5, 2, 0));
    wr(8'hbc, 8'h08);
    rd(8'hc0, st(1, 3, 3, 0));
    rd(8'hbc, {26'h0, 8'h08});
    // Service, equal level held off, strictly higher pre-empts
    wr(8'hbc, 8'h00);
    wr(8'hb8, 8'h00);
    pulse(1'b1);
    rd(8'hc0, st(0, 0, 0, 4'h1), INV_M);
    wr(8'hb8, 8'h20);
    rd(8'hc0, st(1, 5, 1, 4'h1));
    pulse(1'b1);
    rd(8'hc0, st(0, 0, 0, 4'h3), INV_M);
    pulse(1'b0);
    rd(8'hc0, st(1, 5, 1, 4'h1));
    // Mid-run reset clears registers and service state
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'ha8, 34'h0);
    rd(8'hb8, 34'h0);
    rd(8'hc0, 34'h0);
    repeat (4) @(posedge aclk);
    wrap_up;
  end
endmodule
